// ### inc/bocd_pkg.sv
`default_nettype none

package bocd_pkg;

  // ****************************************
  // Widths, reset values and step sizes.
  // ****************************************
  localparam int unsigned   PC_W      = 10;
  localparam int unsigned   SP_W      = 3;
  localparam logic [9:0]    PC_RST    = 10'h000;
  localparam logic [7:0]    ACCUM_RST = 8'h00;
  localparam logic [2:0]    SP_RST    = 3'h0;
  localparam logic          ZERO_RST  = 1'b0;
  localparam logic [9:0]    PC_STEP   = 10'h001;
  localparam logic [2:0]    SP_STEP   = 3'h1;

  // ****************************************
  // Decoded operations and sequencer states.
  // ****************************************
  typedef enum logic [2:0] {
    OP_OTHER = 3'b000,
    OP_BCLR  = 3'b001,
    OP_BSET  = 3'b010,
    OP_ANDI  = 3'b011,
    OP_TSZ   = 3'b100,
    OP_CALL  = 3'b101
  } bocd_op_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SKIP  = 2'b01,
    ST_CALL2 = 2'b10
  } bocd_state_t;

  // Fetched instruction as handed over by the decode stage.
  typedef struct packed {
    bocd_op_t   op;
    logic [5:0] reg_addr;
    logic [2:0] bit_idx;
    logic [7:0] imm;
  } bocd_instr_t;

  // Write toward the data register file.
  typedef struct packed {
    logic       we;
    logic [5:0] addr;
    logic [7:0] data;
  } bocd_regwr_t;

  // Whole state of the core slice.
  typedef struct packed {
    bocd_state_t state;
    logic [9:0]  pc;
    logic [7:0]  accumulator;
    logic        zero;
    logic [2:0]  sp;
    bocd_regwr_t wr;
    logic        push;
    logic [9:0]  push_data;
  } bocd_core_t;

endpackage : bocd_pkg

`default_nettype wire

// ### rtl/bocd_core.sv
`default_nettype none

module bocd_core
  import bocd_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        instr_valid_i,
  input  wire bocd_instr_t instr_i,
  input  wire logic [7:0]  reg_rdata_i,
  input  wire logic [1:0]  page_hi_i,
  output logic             instr_ready_o,
  output logic             discard_o,
  output logic [5:0]       reg_raddr_o,
  output bocd_regwr_t      reg_wr_o,
  output logic [7:0]       accumulator_o,
  output logic             zero_o,
  output logic [9:0]       pc_o,
  output logic             stack_push_o,
  output logic [9:0]       stack_data_o,
  output logic [2:0]       stack_ptr_o
);

  // ****************************************
  // Decode helpers.
  // ****************************************

  // One-hot mask for a bit index; used by clear, set and test.
  function automatic logic [7:0] bit_mask(input logic [2:0] idx);
    bit_mask = 8'h01 << idx;
  endfunction : bit_mask

  bocd_core_t  st_r;
  bocd_core_t  st_nxt;
  logic        take;
  logic [7:0]  mask;
  logic [7:0]  clr_val;
  logic [7:0]  set_val;
  logic [7:0]  and_val;
  logic        tested_bit;
  logic [9:0]  pc_inc;
  logic [9:0]  call_tgt;

  // The register file answers the read address in the same cycle.
  assign reg_raddr_o   = instr_i.reg_addr;
  assign instr_ready_o = (st_r.state == ST_IDLE);
  assign take          = instr_valid_i && instr_ready_o;
  assign mask          = bit_mask(instr_i.bit_idx);
  assign clr_val       = reg_rdata_i & ~mask;
  assign set_val       = reg_rdata_i | mask;
  assign and_val       = st_r.accumulator & instr_i.imm;
  assign tested_bit    = |(reg_rdata_i & mask);
  assign pc_inc        = st_r.pc + PC_STEP;
  assign call_tgt      = {page_hi_i, instr_i.imm};

  // ****************************************
  // Next-state logic.
  // ****************************************

  // Pulses are cleared each cycle so that a write or push lasts one cycle.
  always_comb begin
    st_nxt         = st_r;
    st_nxt.wr.we   = 1'b0;
    st_nxt.push    = 1'b0;
    case (st_r.state)
      ST_IDLE: begin
        if (take) begin
          st_nxt.pc = pc_inc;
          case (instr_i.op)
            OP_BCLR: begin
              st_nxt.wr = '{we: 1'b1, addr: instr_i.reg_addr,
                            data: clr_val};
            end
            OP_BSET: begin
              st_nxt.wr = '{we: 1'b1, addr: instr_i.reg_addr,
                            data: set_val};
            end
            OP_ANDI: begin
              st_nxt.accumulator = and_val;
              st_nxt.zero        = (and_val == 8'h00);
            end
            OP_TSZ: begin
              if (!tested_bit) begin
                st_nxt.state = ST_SKIP;
              end
              // A set bit leaves the sequencer idle.
            end
            OP_CALL: begin
              st_nxt.push      = 1'b1;
              st_nxt.push_data = pc_inc;
              st_nxt.pc        = call_tgt;
              st_nxt.sp        = st_r.sp + SP_STEP;
              st_nxt.state     = ST_CALL2;
            end
            default: begin
            end
          endcase
        end
      end
      ST_SKIP: begin
        // The discarded word still moves the counter past itself.
        st_nxt.pc    = pc_inc;
        st_nxt.state = ST_IDLE;
      end
      ST_CALL2: begin
        // Second call cycle: the word fetched behind the call is dropped.
        st_nxt.state = ST_IDLE;
      end
      default: begin
        st_nxt.state = ST_IDLE;
      end
    endcase
  end

  // ****************************************
  // State register.
  // ****************************************

  // Reset takes constants only; flags and counters start cleared.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_r.state     <= ST_IDLE;
      st_r.pc        <= PC_RST;
      st_r.accumulator <= ACCUM_RST;
      st_r.zero      <= ZERO_RST;
      st_r.sp        <= SP_RST;
      st_r.wr        <= '0;
      st_r.push      <= 1'b0;
      st_r.push_data <= PC_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Discard tells fetch that the word on its output is dead this cycle.
  assign discard_o    = (st_r.state != ST_IDLE);
  assign reg_wr_o     = st_r.wr;
  assign accumulator_o = st_r.accumulator;
  assign zero_o       = st_r.zero;
  assign pc_o         = st_r.pc;
  assign stack_push_o = st_r.push;
  assign stack_data_o = st_r.push_data;
  assign stack_ptr_o  = st_r.sp;

  // ****************************************
  // Assertions.
  // ****************************************

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  // Expectations are rebuilt from sampled inputs rather than from the
  // helper nets above, so a slip in a helper cannot hide behind itself.
  sequence s_skip_seq;
    (st_r.state == ST_SKIP) && discard_o ##1 (st_r.state == ST_IDLE);
  endsequence

  sequence s_call_seq;
    stack_push_o && (st_r.state == ST_CALL2) ##1 (st_r.state == ST_IDLE);
  endsequence

  a_bit_clear_val: assert property (
    take && instr_i.op == OP_BCLR |=> reg_wr_o.we &&
      reg_wr_o.addr == $past(instr_i.reg_addr) &&
      reg_wr_o.data == ($past(reg_rdata_i) &
                        ~(8'h01 << $past(instr_i.bit_idx))) &&
      instr_ready_o)
    else $error("bit clear wrote a wrong value");

  a_bit_set_val: assert property (
    take && instr_i.op == OP_BSET |=> reg_wr_o.we &&
      reg_wr_o.addr == $past(instr_i.reg_addr) &&
      reg_wr_o.data == ($past(reg_rdata_i) |
                        (8'h01 << $past(instr_i.bit_idx))) &&
      $stable(zero_o) && instr_ready_o)
    else $error("bit set wrote a wrong value or touched a flag");

  a_and_accum_val: assert property (
    take && instr_i.op == OP_ANDI |=> accumulator_o ==
      ($past(accumulator_o) & $past(instr_i.imm)) &&
      !reg_wr_o.we && instr_ready_o)
    else $error("immediate and gave a wrong accumulator");

  a_zero_flag_val: assert property (
    take && instr_i.op == OP_ANDI |=> zero_o == (accumulator_o == 8'h00))
    else $error("zero flag disagrees with and result");

  a_skip_two_cyc: assert property (
    take && instr_i.op == OP_TSZ && !reg_rdata_i[instr_i.bit_idx] |=>
      s_skip_seq)
    else $error("skip did not last exactly two cycles");

  a_skip_pc_two: assert property (
    take && instr_i.op == OP_TSZ && !reg_rdata_i[instr_i.bit_idx] |=>
      ##1 pc_o == 10'($past(pc_o, 2) + PC_STEP + PC_STEP))
    else $error("skip did not move the counter past the dead word");

  // A word offered while fetch is told to drop it must leave no trace.
  a_dead_word_drop: assert property (
    discard_o |=> !reg_wr_o.we && !stack_push_o && instr_ready_o)
    else $error("a word offered during discard was executed");

  a_no_skip_one: assert property (
    take && instr_i.op == OP_TSZ && reg_rdata_i[instr_i.bit_idx] |=>
      !discard_o && $stable(zero_o) && $stable(accumulator_o) &&
      !reg_wr_o.we)
    else $error("test with set bit did not complete in one cycle");

  a_call_push_ret: assert property (
    take && instr_i.op == OP_CALL |=>
      stack_data_o == 10'($past(pc_o) + PC_STEP))
    else $error("call pushed a wrong return address");

  a_call_pc_load: assert property (
    take && instr_i.op == OP_CALL |=>
      pc_o == {$past(page_hi_i), $past(instr_i.imm)} ##1
      pc_o == $past(pc_o))
    else $error("call loaded a wrong program counter");

  a_call_sp_two: assert property (
    take && instr_i.op == OP_CALL |=> s_call_seq and
      (stack_ptr_o == 3'($past(stack_ptr_o) + SP_STEP) &&
       $stable(zero_o)))
    else $error("call stack pointer or length wrong");

endmodule : bocd_core

`default_nettype wire

// ### test/bit_ops_call_decode_tb.sv
`default_nettype none

module bit_ops_call_decode_tb
  import bocd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // Signals, model state and counters.
  // ****************************************
  logic        clk_i;
  logic        rstn_i;
  logic        instr_valid_i;
  bocd_instr_t instr_i;
  logic [7:0]  reg_rdata_i;
  logic [1:0]  page_hi_i;
  logic        instr_ready_o;
  logic        discard_o;
  logic [5:0]  reg_raddr_o;
  bocd_regwr_t reg_wr_o;
  logic [7:0]  accumulator_o;
  logic        zero_o;
  logic [9:0]  pc_o;
  logic        stack_push_o;
  logic [9:0]  stack_data_o;
  logic [2:0]  stack_ptr_o;
  int          num_errors  = 0;
  int          comparisons = 0;
  int          cycles      = 0;
  int          m_pc, m_accum, m_zero, m_sp, m_sd;

  bocd_core dut (
    .clk_i(clk_i), .rstn_i(rstn_i), .instr_valid_i(instr_valid_i),
    .instr_i(instr_i), .reg_rdata_i(reg_rdata_i), .page_hi_i(page_hi_i),
    .instr_ready_o(instr_ready_o), .discard_o(discard_o),
    .reg_raddr_o(reg_raddr_o), .reg_wr_o(reg_wr_o),
    .accumulator_o(accumulator_o),
    .zero_o(zero_o), .pc_o(pc_o), .stack_push_o(stack_push_o),
    .stack_data_o(stack_data_o), .stack_ptr_o(stack_ptr_o)
  );

  // Free running core clock at 100 MHz.
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Cuts a hang short; a full run needs about 570 cycles.
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  // ****************************************
  // Comparison and stimulus tasks.
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Compares every registered output except the write address and data with the model after one edge.
  task automatic common(input logic we, input logic push, input logic dsc);
    chk(32'(pc_o), 32'(m_pc));
    chk(32'(accumulator_o), 32'(m_accum));
    chk(32'(zero_o), 32'(m_zero));
    chk(32'(stack_ptr_o), 32'(m_sp));
    chk(32'(reg_wr_o.we), 32'(we));
    chk(32'(stack_push_o), 32'(push));
    chk(32'(stack_data_o), 32'(m_sd));
    chk(32'(discard_o), 32'(dsc));
    chk(32'(instr_ready_o), 32'(!dsc));
  endtask : common

  // Offers one instruction and, for the two-cycle cases, a dead word
  // that would write a register if it were wrongly taken.
  task automatic issue(input bocd_op_t op, input logic [5:0] a,
                       input logic [2:0] b, input logic [7:0] imm,
                       input logic [7:0] rd, input logic [1:0] pg);
    logic [7:0] mask;
    logic       skip;
    logic       wr;
    mask = 8'h01 << b;
    skip = (op == OP_TSZ) && !rd[b];
    wr = (op == OP_BCLR) || (op == OP_BSET);
    instr_valid_i = 1'b1;
    instr_i = '{op, a, b, imm};
    reg_rdata_i = rd;
    page_hi_i = pg;
    @(posedge clk_i);
    #1;
    chk(32'(reg_raddr_o), 32'(a));
    if (op == OP_CALL) begin
      m_sd = (m_pc + 1) % 1024;
      m_pc = int'({pg, imm});
      m_sp = (m_sp + 1) % 8;
    end else begin
      m_pc = (m_pc + 1) % 1024;
    end
    if (op == OP_ANDI) begin
      m_accum = m_accum & int'(imm);
      m_zero = (m_accum == 0);
    end
    common(wr, op == OP_CALL, skip || op == OP_CALL);
    if (wr) begin
      chk(32'(reg_wr_o.addr), 32'(a));
      chk(32'(reg_wr_o.data),
          32'(op == OP_BCLR ? rd & ~mask : rd | mask));
    end
    if (skip || op == OP_CALL) begin
      instr_i = '{OP_BSET, a, b, imm};
      @(posedge clk_i);
      #1;
      if (skip) m_pc = (m_pc + 1) % 1024;
      common(1'b0, 1'b0, 1'b0);
    end
  endtask : issue

  // One cycle with nothing offered; nothing may move.
  task automatic idle();
    instr_valid_i = 1'b0;
    @(posedge clk_i);
    #1;
    common(1'b0, 1'b0, 1'b0);
  endtask : idle

  task automatic tally_and_finish();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish

  // ****************************************
  // Main sequence.
  // ****************************************
  initial begin
    instr_valid_i = 1'b0;
    instr_i = '0;
    reg_rdata_i = 8'h00;
    page_hi_i = 2'h0;
    rstn_i = 1'b0;
    {m_pc, m_accum, m_zero, m_sp, m_sd} = '0;
    void'($urandom(32'h3650));
    repeat (12) @(posedge clk_i);
    #1;
    rstn_i = 1'b1;
    common(1'b0, 1'b0, 1'b0);
    // Boundary cases first, the flag-setting AND last, since the
    // accumulator can only ever hold zero once reset.
    issue(OP_BCLR, 6'h3f, 3'h3, 8'h00, 8'h5a, 2'h0);
    issue(OP_BSET, 6'h00, 3'h2, 8'h00, 8'h5a, 2'h0);
    issue(OP_TSZ, 6'h05, 3'h2, 8'h00, 8'h5a, 2'h1);
    issue(OP_TSZ, 6'h05, 3'h7, 8'h00, 8'h80, 2'h1);
    issue(OP_CALL, 6'h00, 3'h0, 8'hff, 8'h00, 2'h3);
    issue(OP_ANDI, 6'h00, 3'h0, 8'haf, 8'h00, 2'h0);
    idle();
    repeat (400) begin
      issue(bocd_op_t'(3'($urandom_range(5))), 6'($urandom),
            3'($urandom), 8'($urandom), 8'($urandom), 2'($urandom));
      if ($urandom_range(7) == 0) idle();
    end
    tally_and_finish();
  end

endmodule : bit_ops_call_decode_tb

`default_nettype wire
